// *** inc/sac_pkg.sv ***
// constants, types and helpers shared by the converter control logic
package sac_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned RES_BITS      = 8;
  localparam int unsigned CONV_CYC      = 64;
  localparam int unsigned BIT_CYC       = CONV_CYC / RES_BITS;
  localparam int unsigned CNT_W         = $clog2(CONV_CYC);
  localparam int unsigned PH_W          = $clog2(BIT_CYC);
  localparam int unsigned START_DLY_MIN = 1;
  localparam int unsigned START_DLY_MAX = 8;
  localparam int unsigned SYNC_STAGES   = 2;
  // two sync edges plus this delay stays inside the 1..8 clock window
  localparam int unsigned START_DLY_CYC = 4;

  localparam logic [CNT_W-1:0]    CNT_LAST   = 6'h3F;
  localparam logic [PH_W-1:0]     PH_LAST    = 3'h7;
  localparam logic [3:0]          DLY_LAST   = 4'h3;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [RES_BITS-1:0] RESULT_RST = 8'h00;
  localparam logic [RES_BITS-1:0] SAR_RST    = 8'h00;
  localparam logic                DONE_N_RST = 1'b1;
  localparam logic                OE_N_RST   = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_CLEAR,
    SAC_WAIT,
    SAC_CONV
  } sac_state_t;

  typedef struct packed {
    logic sel_n;
    logic start_n;
    logic read_n;
  } sac_strobe_t;

  localparam sac_strobe_t STROBE_RST = 3'h7;

  // both active-low strobes asserted
  function automatic logic sac_pair_low(input logic a_n, input logic b_n);
    sac_pair_low = ~a_n & ~b_n;
  endfunction : sac_pair_low

endpackage : sac_pkg

// *** core/sac_top.sv ***
// successive-approximation converter control with bus strobes and latched result
`timescale 1ns/10ps
`default_nettype none

module sac_top
  import sac_pkg::*;
(
  input  wire logic                CORE_CLK,
  input  wire logic                RST_N,
  input  wire logic                CLK_EN,
  input  wire logic                SEL_N,
  input  wire logic                START_N,
  input  wire logic                READ_N,
  input  wire logic                COMP_HIGH,
  output var  logic [RES_BITS-1:0] TRIAL_CODE,
  output var  logic [RES_BITS-1:0] DATA_OUT,
  output var  logic                DATA_OE_N,
  output var  logic                CONVERSION_DONE_N
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sac_strobe_t strb_s1;
  sac_strobe_t strb_s2;
  logic        comp_s1;
  logic        comp_s2;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      strb_s1 <= STROBE_RST;
      strb_s2 <= STROBE_RST;
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
    end
    else if (CLK_EN)
    begin
      strb_s1 <= '{sel_n: SEL_N, start_n: START_N, read_n: READ_N};
      strb_s2 <= strb_s1;
      comp_s1 <= COMP_HIGH;
      comp_s2 <= comp_s1;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  sac_state_t             state;
  sac_state_t             next_state;
  logic [CNT_W-1:0]       cyc_cnt;
  logic [CNT_W-1:0]       next_cyc_cnt;
  logic [3:0]             dly_cnt;
  logic [3:0]             next_dly_cnt;
  logic [RES_BITS-1:0]    approximation_register;
  logic [RES_BITS-1:0]    next_sar;
  logic [RES_BITS-1:0]    result;
  logic [RES_BITS-1:0]    next_result;
  logic                   next_done_n;

  wire                    start_hold = sac_pair_low(strb_s2.sel_n, strb_s2.start_n);
  wire                    read_on    = sac_pair_low(strb_s2.sel_n, strb_s2.read_n);
  wire [PH_W-1:0]         phase      = cyc_cnt[PH_W-1:0];
  wire [PH_W-1:0]         bit_idx    = PH_LAST - cyc_cnt[CNT_W-1:PH_W];
  wire [RES_BITS-1:0]     bit_mask   = RES_BITS'(1) << bit_idx;
  wire                    in_conv    = (state == SAC_CONV);
  // trial bit goes up at the head of each bit slot, msb first
  wire                    bit_head   = in_conv && (phase == '0);
  // decision late in the slot so the synchronised comparator has settled
  wire                    bit_tail   = in_conv && (phase == PH_LAST);
  wire                    conv_last  = in_conv && (cyc_cnt == CNT_LAST);
  wire                    dly_done   = (state == SAC_WAIT) && (dly_cnt == DLY_LAST);
  wire [RES_BITS-1:0]     sar_set    = approximation_register | bit_mask;
  wire [RES_BITS-1:0]     sar_keep   = comp_s2 ? approximation_register : (approximation_register & ~bit_mask);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state   = state;
    next_cyc_cnt = cyc_cnt;
    next_dly_cnt = dly_cnt;
    next_sar     = approximation_register;
    next_result  = result;
    next_done_n  = CONVERSION_DONE_N;
    case (state)
      SAC_IDLE:
      begin
        next_state = SAC_IDLE;
      end
      SAC_CLEAR:
      begin
        next_sar     = SAR_RST;
        next_dly_cnt = '0;
        if (!start_hold)
          next_state = SAC_WAIT;
      end
      SAC_WAIT:
      begin
        next_dly_cnt = dly_cnt + 4'h1;
        if (dly_done)
        begin
          next_state   = SAC_CONV;
          next_cyc_cnt = '0;
          next_done_n  = 1'b1;
        end
      end
      SAC_CONV:
      begin
        next_cyc_cnt = cyc_cnt + CNT_W'(1);
        if (bit_head)
          next_sar = sar_set;
        else if (bit_tail)
          next_sar = sar_keep;
        if (conv_last)
        begin
          next_result = sar_keep;
          next_done_n = 1'b0;
          next_state  = SAC_IDLE;
        end
      end
      default:
      begin
        next_state = SAC_IDLE;
      end
    endcase
    // a start overrides whatever is running, including a half-done word
    if (start_hold)
    begin
      next_state  = SAC_CLEAR;
      next_sar    = SAR_RST;
      next_done_n = 1'b0;
    end
    else if (read_on)
      next_done_n = 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      state   <= SAC_IDLE;
      cyc_cnt <= '0;
      dly_cnt <= '0;
    end
    else if (CLK_EN)
    begin
      state   <= next_state;
      cyc_cnt <= next_cyc_cnt;
      dly_cnt <= next_dly_cnt;
    end
  end

  // working register and the latch the bus reads from
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      approximation_register    <= SAR_RST;
      result <= RESULT_RST;
    end
    else if (CLK_EN)
    begin
      approximation_register    <= next_sar;
      result <= next_result;
    end
  end

  // done is a level; it moves only at a start, a read, a begin or an end
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      CONVERSION_DONE_N <= DONE_N_RST;
    end
    else if (CLK_EN)
    begin
      CONVERSION_DONE_N <= next_done_n;
    end
  end

  // ----------------------------------------------------------------
  // trial code and bus side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      TRIAL_CODE <= SAR_RST;
    end
    else if (CLK_EN)
    begin
      TRIAL_CODE <= next_sar;
    end
  end

  // data only leaves the latch, never the working register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      DATA_OUT <= RESULT_RST;
    end
    else if (CLK_EN)
    begin
      DATA_OUT <= next_result;
    end
  end

  // enable follows the synchronised strobes, so it lags the pins by three edges
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      DATA_OE_N <= OE_N_RST;
    end
    else if (CLK_EN)
    begin
      DATA_OE_N <= ~read_on;
    end
  end

endmodule : sac_top

`default_nettype wire

// *** tb/sac_comp_model.sv ***
// comparator stand-in that faces the trial code
`timescale 1ns/10ps
`default_nettype none
module sac_comp_model
  import sac_pkg::*;
(
  input  wire logic [RES_BITS-1:0] trial_code,
  input  wire logic [RES_BITS-1:0] sample,
  output var  logic                comp_high
);
  assign comp_high = (sample >= trial_code);
endmodule : sac_comp_model
`default_nettype wire

// *** tb/sac_top_properties.sv ***
// port assertions for the converter control
`timescale 1ns/10ps
`default_nettype none
module sac_top_checker
  import sac_pkg::*;
(
  input wire logic                CORE_CLK,
  input wire logic                RST_N,
  input wire logic                SEL_N,
  input wire logic                START_N,
  input wire logic                READ_N,
  input wire logic [RES_BITS-1:0] TRIAL_CODE,
  input wire logic [RES_BITS-1:0] DATA_OUT,
  input wire logic                DATA_OE_N,
  input wire logic                CONVERSION_DONE_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       done_q;
  // count only after a rise, so idle time never looks like a long conversion
  assign next_cnt = (CONVERSION_DONE_N && (cnt != 7'h00 || !done_q)) ? cnt + 7'h01 : 7'h00;
  always_ff @(posedge CORE_CLK)
  begin
    cnt    <= RST_N ? next_cnt : 7'h00;
    done_q <= RST_N ? CONVERSION_DONE_N : 1'b1;
  end
  property p_oe; !DATA_OE_N == (!$past(SEL_N, 3) && !$past(READ_N, 3)); endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_clear; (!SEL_N && !START_N)[*3] |-> ##3 (TRIAL_CODE == 8'h00 && !CONVERSION_DONE_N);
  endproperty
  a_clear: assert property (p_clear) else $error("trial code not held clear");
  property p_delay; (!SEL_N && !START_N)[*3] ##1 (SEL_N || START_N)[*8] |->
    CONVERSION_DONE_N && !$past(CONVERSION_DONE_N, 2); endproperty
  a_delay: assert property (p_delay) else $error("conversion start delay wrong");
  property p_rise; $rose(CONVERSION_DONE_N) |-> $past(SEL_N, 7) || $past(START_N, 7); endproperty
  a_rise: assert property (p_rise) else $error("done rose without release");
  property p_len; cnt == 7'h40 |-> !CONVERSION_DONE_N; endproperty
  a_len: assert property (p_len) else $error("conversion longer than 64 clocks");
  property p_latch; $changed(DATA_OUT) |-> $fell(CONVERSION_DONE_N) && cnt == 7'h40; endproperty
  a_latch: assert property (p_latch) else $error("result latch moved early");
  property p_msb; $rose(CONVERSION_DONE_N) |-> ##[0:3] TRIAL_CODE == 8'h80; endproperty
  a_msb: assert property (p_msb) else $error("first trial not msb");
  property p_read_done; !DATA_OE_N |-> !CONVERSION_DONE_N; endproperty
  a_read_done: assert property (p_read_done) else $error("done high during read");
endmodule : sac_top_checker
bind sac_top sac_top_checker sac_top_checker_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .SEL_N(SEL_N), .START_N(START_N), .READ_N(READ_N), .TRIAL_CODE(TRIAL_CODE),
  .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .CONVERSION_DONE_N(CONVERSION_DONE_N));
`default_nettype wire

// *** tb/sac_top_test.sv ***
// self-checking bench for the converter control
`timescale 1ns/10ps
`default_nettype none
module sac_top_test;
  import sac_pkg::*;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  sac_strobe_t         strobe = STROBE_RST;
  logic                comp;
  logic                oe_n;
  logic                done_n;
  logic [RES_BITS-1:0] sample = 8'h00;
  logic [RES_BITS-1:0] trial;
  logic [RES_BITS-1:0] dout;
  int                  fail_count = 0;
  int                  n_compared = 0;
  int                  cyc = 0;
  always #4 clk = ~clk;
  sac_top sac_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .SEL_N(strobe.sel_n),
    .START_N(strobe.start_n), .READ_N(strobe.read_n), .COMP_HIGH(comp), .TRIAL_CODE(trial),
    .DATA_OUT(dout), .DATA_OE_N(oe_n), .CONVERSION_DONE_N(done_n));
  sac_comp_model sac_comp_model_inst (.trial_code(trial), .sample(sample), .comp_high(comp));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // watchdog: fail and end the run after 3000 clocks; the wait loops in the tasks give up on their own after 20 or 200 clocks
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic convert(input logic [7:0] s, input logic [7:0] prev);
    int n;
    sample = s;
    strobe = 3'h1;
    idle(4);
    check(trial, 8'h00);
    check({7'h00, done_n}, 8'h00);
    check(dout, prev);
    strobe = 3'h7;
    for (n = 0; done_n !== 1'b1 && n < 20; n++) idle(1);
    check(n[7:0], 8'h07);
    for (; done_n !== 1'b0 && n < 200; n++) idle(1);
    check(n[7:0], 8'h47);
    check(dout, s);
  endtask : convert
  task automatic read(input logic [7:0] exp);
    strobe = 3'h2;
    idle(3);
    check({7'h00, oe_n}, 8'h00);
    check({7'h00, done_n}, 8'h00);
    check(dout, exp);
    strobe = 3'h7;
    idle(3);
    check({7'h00, oe_n}, 8'h01);
  endtask : read
  // restart mid-conversion; the old result must survive the abort
  task automatic abort(input logic [7:0] prev);
    sample = 8'h33;
    strobe = 3'h1;
    idle(4);
    strobe = 3'h7;
    idle(30);
    check({7'h00, done_n}, 8'h01);
    read(prev);
    convert(8'hC4, prev);
  endtask : abort
  // select grounded: start pulses alone convert, read alone drives the bus
  task automatic standalone(input logic [7:0] s);
    int n;
    sample = s;
    strobe = 3'h3;
    idle(3);
    strobe = 3'h1;
    idle(4);
    check(trial, 8'h00);
    strobe = 3'h3;
    for (n = 0; done_n !== 1'b1 && n < 20; n++) idle(1);
    check(n[7:0], 8'h07);
    for (; done_n !== 1'b0 && n < 200; n++) idle(1);
    check(n[7:0], 8'h47);
    strobe = 3'h2;
    idle(3);
    check({7'h00, oe_n}, 8'h00);
    check(dout, s);
    strobe = 3'h3;
    idle(3);
    check({7'h00, oe_n}, 8'h01);
    strobe = 3'h7;
  endtask : standalone
  initial
  begin
    idle(10);
    rst_n = 1'b1;
    idle(2);
    convert(8'h00, 8'h00);
    convert(8'hFF, 8'h00);
    convert(8'h80, 8'hFF);
    convert(8'h7F, 8'h80);
    convert(8'h5A, 8'h7F);
    read(8'h5A);
    abort(8'h5A);
    read(8'hC4);
    standalone(8'h96);
    end_of_test();
  end
endmodule : sac_top_test
`default_nettype wire
